// [eepw_defs.vh]
// Constants for the EEPROM page write access block
`ifndef EEPW_DEFS_VH
`define EEPW_DEFS_VH

// ------------------------------------------------------------------------
// Array geometry
// ------------------------------------------------------------------------
`define EEPW_ADDR_W        11
`define EEPW_SIZE          2048
`define EEPW_PAGE_BYTES    128
`define EEPW_IDX_W         7
`define EEPW_ROW_W         4
`define EEPW_IDX_LAST      7'h7f
`define EEPW_EE_TOP        16'h07ff

// ------------------------------------------------------------------------
// Register byte addresses (word aligned)
// ------------------------------------------------------------------------
`define EEPW_REG_CTRL      4'h0
`define EEPW_REG_STAT      4'h4
`define EEPW_REG_MASK      4'h8

// ------------------------------------------------------------------------
// Control register fields and launch codes
// ------------------------------------------------------------------------
`define EEPW_CTRL_BUSY     0
`define EEPW_CTRL_MAP      1
`define EEPW_CODE_ARM      4'h5
`define EEPW_CODE_GO       4'ha
`define EEPW_CTRL_RST      1'b0

// ------------------------------------------------------------------------
// Interrupt status fields
// ------------------------------------------------------------------------
`define EEPW_ST_DONE       0
`define EEPW_ST_ABORT      1
`define EEPW_ST_W          2
`define EEPW_ST_RST        2'h0

// ------------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------------
`define EEPW_CLK_NS        10
`define EEPW_ROW_PROG_NS   2000
`define EEPW_ROW_PROG_CYC  ((`EEPW_ROW_PROG_NS + `EEPW_CLK_NS - 1) / `EEPW_CLK_NS)
`define EEPW_TMR_W         12
`define EEPW_TMR_LAST      12'h001

`endif

// [eepw_array.v]
// EEPROM storage array with one synchronous read and one write port
`timescale 1ns/1ps
`include "eepw_defs.vh"

module eepw_array (
    input  wire                     clk_i,
    input  wire                     we_i,
    input  wire [`EEPW_ADDR_W-1:0]  waddr_i,
    input  wire [7:0]               wdata_i,
    input  wire [`EEPW_ADDR_W-1:0]  raddr_i,
    output reg  [7:0]               rdata_o
);

    reg [7:0] mem [0:`EEPW_SIZE-1];

    // Write and registered read
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end

endmodule

// [eepw_top.v]
// EEPROM page write access: mapping, column latches, row programming
//
// Overview of operation
// - Control map bit places the 2K EEPROM over 0000h..07FFh.
// - Mapped external-move reads return the EEPROM byte, not RAM.
// - Write happens in two phases: load latches, then program a row.
// - Page of 128 latches; programming accepts one to 128 loaded bytes.
// - Each latch has a written flag; only flagged bytes get programmed.
// - Loading a latch sets its written flag.
// - Finishing a row program clears every written flag.
// - Mapped external-move write loads one byte into the addressed latch.
// - Address bits 10:7 pick the row, bits 6:0 pick the byte.
// - Programming starts only on control write 5xh then Axh.
// - Any instruction between the two launch writes aborts the launch.
// - Busy flag set while programming, reads blocked, cleared at end.
// - Mixed pages: last loaded page is programmed, other bytes dropped.
//
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`include "eepw_defs.vh"

module eepw_top (
    input  wire         clk_i,
    input  wire         rst_i,
    // Wishbone classic slave
    input  wire         wb_cyc_i,
    input  wire         wb_stb_i,
    input  wire         wb_we_i,
    input  wire [3:0]   wb_adr_i,
    input  wire [3:0]   wb_sel_i,
    input  wire [31:0]  wb_dat_i,
    output reg  [31:0]  wb_dat_o,
    output reg          wb_ack_o,
    // External-move cycles from the core
    input  wire         xm_rd_i,
    input  wire         xm_wr_i,
    input  wire [15:0]  xm_addr_i,
    input  wire [7:0]   xm_wdata_i,
    input  wire         insn_i,
    output reg  [7:0]   xm_rdata_o,
    output reg          xm_rvalid_o,
    output reg          xm_ram_o,
    // Interrupt
    output reg          irq_o
);

    // --------------------------------------------------------------------
    // States
    // --------------------------------------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_WALK = 2'h1;
    localparam ST_WAIT = 2'h2;

    // Wait count cut to the timer width on purpose
    localparam integer           PROG_CYC_I = `EEPW_ROW_PROG_CYC;
    localparam [`EEPW_TMR_W-1:0] PROG_CYC   = PROG_CYC_I[`EEPW_TMR_W-1:0];

    // Address falls inside the EEPROM window
    function ee_hit;
        input [15:0] a;
        begin
            ee_hit = (a <= `EEPW_EE_TOP);
        end
    endfunction

    // Control state, latches and status storage
    reg                     map_r;
    reg                     busy_r;
    reg                     arm_r;
    reg [1:0]               state_r;
    reg [`EEPW_IDX_W-1:0]   idx_r;
    reg [`EEPW_TMR_W-1:0]   tmr_r;
    reg [`EEPW_ROW_W-1:0]   page_r;
    reg [`EEPW_PAGE_BYTES-1:0] flag_r;
    reg [7:0]               lat_mem [0:`EEPW_PAGE_BYTES-1];
    reg [`EEPW_ST_W-1:0]    stat_r;
    reg [`EEPW_ST_W-1:0]    mask_r;
    reg                     ee_rd_r;

    // Single-cycle strobes and next status from combinational decode
    reg                     go_pulse;
    reg                     abort_pulse;
    reg                     done_pulse;
    reg [`EEPW_ST_W-1:0]    stat_nxt;

    // Bus and address decode nets
    wire                    wb_req;
    wire                    wb_wr;
    wire                    ctrl_wr;
    wire [3:0]              code;
    wire                    xm_ee_rd;
    wire                    xm_ee_wr;
    wire [`EEPW_ROW_W-1:0]  xm_row;
    wire [`EEPW_IDX_W-1:0]  xm_idx;
    wire                    arr_we;
    wire [7:0]              arr_rdata;

    // --------------------------------------------------------------------
    // Wishbone decode
    // --------------------------------------------------------------------
    assign wb_req  = wb_cyc_i & wb_stb_i;
    assign wb_wr   = wb_req & wb_we_i & wb_ack_o & wb_sel_i[0];
    assign ctrl_wr = wb_wr & (wb_adr_i == `EEPW_REG_CTRL);
    assign code    = wb_dat_i[7:4];

    // Address split into row and byte index
    assign xm_row  = xm_addr_i[`EEPW_ADDR_W-1:`EEPW_IDX_W];
    assign xm_idx  = xm_addr_i[`EEPW_IDX_W-1:0];

    // EEPROM claims the cycle only when mapped
    assign xm_ee_rd = xm_rd_i & map_r & ee_hit(xm_addr_i);
    assign xm_ee_wr = xm_wr_i & map_r & ee_hit(xm_addr_i);

    // Ack one cycle after the request, dropped the cycle after
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req & ~wb_ack_o;
            wb_dat_o <= 32'h0000_0000;
            if (wb_req & ~wb_ack_o & ~wb_we_i) begin
                case (wb_adr_i)
                    `EEPW_REG_CTRL: begin
                        wb_dat_o[`EEPW_CTRL_BUSY] <= busy_r;
                        wb_dat_o[`EEPW_CTRL_MAP]  <= map_r;
                    end
                    `EEPW_REG_STAT: wb_dat_o[`EEPW_ST_W-1:0] <= stat_r;
                    `EEPW_REG_MASK: wb_dat_o[`EEPW_ST_W-1:0] <= mask_r;
                    default:        wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // --------------------------------------------------------------------
    // Launch sequence and control bits
    // --------------------------------------------------------------------
    // Launch on the armed pair; any instruction, external-move cycle or other register write in between breaks it
    always @* begin
        go_pulse    = 1'b0;
        abort_pulse = 1'b0;
        if (ctrl_wr && code == `EEPW_CODE_GO && arm_r && !busy_r) begin
            go_pulse = 1'b1;
        end else if (arm_r && (insn_i || xm_rd_i || xm_wr_i ||
                               (wb_wr && !ctrl_wr) ||
                               (ctrl_wr && code != `EEPW_CODE_GO))) begin
            abort_pulse = 1'b1;
        end
    end

    // Map bit, arm flag
    always @(posedge clk_i) begin
        if (rst_i) begin
            map_r <= `EEPW_CTRL_RST;
            arm_r <= 1'b0;
        end else begin
            if (ctrl_wr && code != `EEPW_CODE_ARM &&
                code != `EEPW_CODE_GO) begin
                map_r <= wb_dat_i[`EEPW_CTRL_MAP];
            end
            if (ctrl_wr && code == `EEPW_CODE_ARM && !busy_r) begin
                arm_r <= 1'b1;
            end else if (go_pulse || abort_pulse) begin
                arm_r <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------------
    // Column latches and written flags
    // --------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (xm_ee_wr && !busy_r) begin
            lat_mem[xm_idx] <= xm_wdata_i;
        end
    end

    // Flags, last page
    // Done wins; latch writes are refused while busy anyway
    always @(posedge clk_i) begin
        if (rst_i) begin
            flag_r <= {`EEPW_PAGE_BYTES{1'b0}};
            page_r <= {`EEPW_ROW_W{1'b0}};
        end else if (done_pulse) begin
            flag_r <= {`EEPW_PAGE_BYTES{1'b0}};
        end else if (xm_ee_wr && !busy_r) begin
            page_r <= xm_row;
            if (xm_row != page_r) begin
                flag_r <= {`EEPW_PAGE_BYTES{1'b0}};
                flag_r[xm_idx] <= 1'b1;
            end else begin
                flag_r[xm_idx] <= 1'b1;
            end
        end
    end

    // --------------------------------------------------------------------
    // Row programming sequencer
    // --------------------------------------------------------------------
    // Walks every latch; only flagged ones reach the array
    assign arr_we = (state_r == ST_WALK) & flag_r[idx_r];

    // Last wait cycle ends programming
    always @* begin
        done_pulse = (state_r == ST_WAIT) && (tmr_r == `EEPW_TMR_LAST);
    end

    // Phase two: transfer latches into one row
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            busy_r  <= 1'b0;
            idx_r   <= {`EEPW_IDX_W{1'b0}};
            tmr_r   <= {`EEPW_TMR_W{1'b0}};
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (go_pulse) begin
                        state_r <= ST_WALK;
                        busy_r  <= 1'b1;
                        idx_r   <= {`EEPW_IDX_W{1'b0}};
                    end
                end
                ST_WALK: begin
                    idx_r <= idx_r + 1'b1;
                    if (idx_r == `EEPW_IDX_LAST) begin
                        state_r <= ST_WAIT;
                        tmr_r   <= PROG_CYC;
                    end
                end
                ST_WAIT: begin
                    tmr_r <= tmr_r - 1'b1;
                    if (done_pulse) begin
                        state_r <= ST_IDLE;
                        busy_r  <= 1'b0;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    busy_r  <= 1'b0;
                end
            endcase
        end
    end

    eepw_array i_eepw_array (
        .clk_i   (clk_i),
        .we_i    (arr_we),
        .waddr_i ({page_r, idx_r}),
        .wdata_i (lat_mem[idx_r]),
        .raddr_i (xm_addr_i[`EEPW_ADDR_W-1:0]),
        .rdata_o (arr_rdata)
    );

    // --------------------------------------------------------------------
    // External-move answers
    // --------------------------------------------------------------------
    // Read data two cycles after the request; RAM hand-off after one
    always @(posedge clk_i) begin
        if (rst_i) begin
            ee_rd_r     <= 1'b0;
            xm_rvalid_o <= 1'b0;
            xm_rdata_o  <= 8'h00;
            xm_ram_o    <= 1'b0;
        end else begin
            ee_rd_r     <= xm_ee_rd & ~busy_r;
            xm_rvalid_o <= ee_rd_r;
            xm_rdata_o  <= ee_rd_r ? arr_rdata : 8'h00;
            xm_ram_o    <= (xm_rd_i | xm_wr_i) &
                           ~(xm_ee_rd | xm_ee_wr);
        end
    end

    // --------------------------------------------------------------------
    // Interrupt status and mask
    // --------------------------------------------------------------------
    always @* begin
        stat_nxt = stat_r;
        if (wb_wr && wb_adr_i == `EEPW_REG_STAT) begin
            stat_nxt = stat_nxt & ~wb_dat_i[`EEPW_ST_W-1:0];
        end
        stat_nxt[`EEPW_ST_DONE]  = stat_nxt[`EEPW_ST_DONE]  | done_pulse;
        stat_nxt[`EEPW_ST_ABORT] = stat_nxt[`EEPW_ST_ABORT] | abort_pulse;
    end

    // Sticky status, mask, level interrupt
    always @(posedge clk_i) begin
        if (rst_i) begin
            stat_r <= `EEPW_ST_RST;
            mask_r <= `EEPW_ST_RST;
            irq_o  <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            if (wb_wr && wb_adr_i == `EEPW_REG_MASK) begin
                mask_r <= wb_dat_i[`EEPW_ST_W-1:0];
            end
            irq_o <= |(stat_nxt & mask_r);
        end
    end

endmodule

// [eepw_chk.sv]
// Port assertions for the EEPROM page write block
`timescale 1ns/1ps

module eepw_chk (
    input wire        clk_i,
    input wire        rst_i,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        xm_rd_i,
    input wire        xm_wr_i,
    input wire [15:0] xm_addr_i,
    input wire [7:0]  xm_rdata_o,
    input wire        xm_rvalid_o,
    input wire        xm_ram_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // --------------------------------------------------------------------
    // Request steps
    // --------------------------------------------------------------------
    sequence s_wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_xm_far;
        (xm_rd_i || xm_wr_i) && xm_addr_i > 16'h07ff;
    endsequence

    // --------------------------------------------------------------------
    // Properties
    // --------------------------------------------------------------------
    a_ack_reply: assert property (s_wb_req |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_wbdat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_rd_latency: assert property (xm_rvalid_o |->
        $past(xm_rd_i, 2) && $past(xm_addr_i, 2) <= 16'h07ff)
        else $error("read answer without claimed read");
    a_rdata_idle: assert property (!xm_rvalid_o |-> xm_rdata_o == 8'h00)
        else $error("read byte outside valid");
    a_ram_high: assert property (s_xm_far |=> xm_ram_o)
        else $error("far cycle not handed to ram");
    a_ram_cause: assert property (xm_ram_o |-> $past(xm_rd_i || xm_wr_i))
        else $error("ram hand-off without cycle");
endmodule

bind eepw_top eepw_chk i_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .xm_rd_i(xm_rd_i), .xm_wr_i(xm_wr_i),
    .xm_addr_i(xm_addr_i), .xm_rdata_o(xm_rdata_o),
    .xm_rvalid_o(xm_rvalid_o), .xm_ram_o(xm_ram_o));

// [eepw_core_model.sv]
// Behavioural core issuing external-move cycles
`timescale 1ns/1ps

module eepw_core_model (
    input  wire         clk_i,
    output logic        xm_rd_o,
    output logic        xm_wr_o,
    output logic [15:0] xm_addr_o,
    output logic [7:0]  xm_wdata_o,
    output logic        insn_o
);
    // Idle bus at start
    initial begin
        xm_rd_o = 1'b0;
        xm_wr_o = 1'b0;
        xm_addr_o = 16'hffff;
        xm_wdata_o = 8'h00;
        insn_o = 1'b0;
    end

    // One cycle; callers may change the row between cycles, no interrupt entry here
    task xm(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        xm_wr_o <= w;
        xm_rd_o <= !w;
        xm_addr_o <= a;
        xm_wdata_o <= d;
        @(posedge clk_i);
        xm_wr_o <= 1'b0;
        xm_rd_o <= 1'b0;
        xm_addr_o <= ~a; // Released lines show no stale value
        xm_wdata_o <= ~d;
    endtask

    // Some other instruction retires
    task insn;
        @(posedge clk_i);
        insn_o <= 1'b1;
        @(posedge clk_i);
        insn_o <= 1'b0;
    endtask
endmodule

// [eepw_top_bench.sv]
// Self-checking bench for the EEPROM page write block
`timescale 1ns/1ps
`include "eepw_defs.vh"
`define CHK(g, e) begin \
    checks++; \
    if ((g) !== (e)) begin \
        fails++; \
        $display("mismatch at %0t: got %0h want %0h", $time, g, e); \
    end \
end

module eepw_top_bench;
    logic        clk_i, rst_i, cyc, stb, we;
    logic [3:0]  adr;
    logic [31:0] dat;
    wire  [31:0] wq;
    wire  [15:0] xa;
    wire  [7:0]  xd, xq;
    wire         ack, rv, ram, irq, xr, xw, xi;
    int          fails, checks, cycles;

    eepw_top i_eepw_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(dat), .wb_dat_o(wq), .wb_ack_o(ack), .xm_rd_i(xr),
        .xm_wr_i(xw), .xm_addr_i(xa), .xm_wdata_i(xd), .insn_i(xi),
        .xm_rdata_o(xq), .xm_rvalid_o(rv), .xm_ram_o(ram), .irq_o(irq));
    eepw_core_model i_eepw_core_model (.clk_i(clk_i), .xm_rd_o(xr),
        .xm_wr_o(xw), .xm_addr_o(xa), .xm_wdata_o(xd), .insn_o(xi));

    // ------------------------------------------------------------------
    // Clock, timeout and verdict
    // ------------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            fails++;
            finish_test;
        end
    end
    task finish_test;
        $display("fails %0d checks %0d", fails, checks);
        if (fails == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Bus helpers
    // ------------------------------------------------------------------
    task wbx(input logic w, input logic [3:0] a, input logic [7:0] d,
             output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        `CHK(ack, 1'b1)
        q = wq;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        wbx(1'b1, a, d, q);
    endtask
    task rdc(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        wbx(1'b0, a, 8'h00, q);
        `CHK(q, e)
    endtask
    task ld(input logic [15:0] a, input logic [7:0] d);
        i_eepw_core_model.xm(1'b1, a, d);
    endtask
    // Read, then look for ram hand-off and the two-cycle answer
    task xrc(input logic [15:0] a, input logic [7:0] e, input logic r,
             input logic v);
        i_eepw_core_model.xm(1'b0, a, 8'h00);
        @(posedge clk_i);
        `CHK(ram, r)
        @(posedge clk_i);
        `CHK(rv, v)
        `CHK(xq, e)
    endtask
    task go;
        wr(`EEPW_REG_CTRL, 8'h50);
        wr(`EEPW_REG_CTRL, 8'ha0);
    endtask
    task wait_idle;
        logic [31:0] q;
        int n;
        n = 0;
        do begin
            wbx(1'b0, `EEPW_REG_CTRL, 8'h00, q);
            n++;
        end while (q[`EEPW_CTRL_BUSY] !== 1'b0 && n < 200);
        `CHK(q[`EEPW_CTRL_BUSY], 1'b0)
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_reset;
        rdc(`EEPW_REG_CTRL, 32'h0);
        rdc(`EEPW_REG_STAT, 32'h0);
        rdc(`EEPW_REG_MASK, 32'h0);
        rdc(4'hc, 32'h0);
        `CHK(irq, 1'b0)
    endtask
    task t_unmapped;
        xrc(16'h0010, 8'h00, 1'b1, 1'b0);
        ld(16'h0190, 8'hee);
        @(posedge clk_i);
        `CHK(ram, 1'b1)
        wr(`EEPW_REG_CTRL, 8'h02);
        rdc(`EEPW_REG_CTRL, 32'h2);
        xrc(16'h0800, 8'h00, 1'b1, 1'b0);
    endtask
    task t_program;
        wr(`EEPW_REG_MASK, 8'h03);
        ld(16'h0180, 8'h11);
        ld(16'h01ff, 8'h22);
        go;
        rdc(`EEPW_REG_CTRL, 32'h3);
        xrc(16'h0180, 8'h00, 1'b0, 1'b0);
        wait_idle;
        rdc(`EEPW_REG_STAT, 32'h1);
        `CHK(irq, 1'b1)
        wr(`EEPW_REG_STAT, 8'h01);
        repeat (2) @(posedge clk_i);
        `CHK(irq, 1'b0)
        xrc(16'h0180, 8'h11, 1'b0, 1'b1);
        xrc(16'h01ff, 8'h22, 1'b0, 1'b1);
    endtask
    task t_partial;
        ld(16'h0181, 8'h33);
        go;
        wait_idle;
        xrc(16'h0180, 8'h11, 1'b0, 1'b1);
        xrc(16'h0181, 8'h33, 1'b0, 1'b1);
    endtask
    // Row 4 byte 5 keeps 77h although its latch later holds 55h
    task t_mixed;
        ld(16'h0105, 8'h99);
        go;
        wait_idle;
        ld(16'h0205, 8'h77);
        go;
        wait_idle;
        ld(16'h0105, 8'h55);
        ld(16'h0206, 8'h66);
        go;
        wait_idle;
        xrc(16'h0105, 8'h99, 1'b0, 1'b1);
        xrc(16'h0206, 8'h66, 1'b0, 1'b1);
        xrc(16'h0205, 8'h77, 1'b0, 1'b1);
    endtask
    task t_abort;
        wr(`EEPW_REG_STAT, 8'h03);
        wr(`EEPW_REG_MASK, 8'h00);
        wr(`EEPW_REG_CTRL, 8'h50);
        i_eepw_core_model.insn;
        wr(`EEPW_REG_CTRL, 8'ha0);
        rdc(`EEPW_REG_CTRL, 32'h2);
        rdc(`EEPW_REG_STAT, 32'h2);
        `CHK(irq, 1'b0)
        wr(`EEPW_REG_MASK, 8'h03);
        repeat (2) @(posedge clk_i);
        `CHK(irq, 1'b1)
        wr(`EEPW_REG_STAT, 8'h02);
        repeat (2) @(posedge clk_i);
        `CHK(irq, 1'b0)
        wr(`EEPW_REG_CTRL, 8'ha0);
        rdc(`EEPW_REG_CTRL, 32'h2);
        wr(`EEPW_REG_CTRL, 8'h50);
        xrc(16'h0800, 8'h00, 1'b1, 1'b0);
        wr(`EEPW_REG_CTRL, 8'ha0);
        rdc(`EEPW_REG_CTRL, 32'h2);
        rdc(`EEPW_REG_STAT, 32'h2);
        wr(`EEPW_REG_CTRL, 8'h00);
        xrc(16'h0180, 8'h00, 1'b1, 1'b0);
    endtask

    // Main sequence
    initial begin
        rst_i = 1'b1;
        {cyc, stb, we} = 3'h0;
        adr = 4'h0;
        dat = 32'h0;
        {fails, checks, cycles} = '0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_unmapped;
        t_program;
        t_partial;
        t_mixed;
        t_abort;
        finish_test;
    end
endmodule
